//--- rtl/sep_host.sv
/*
 * Host end: APB-programmed two-wire master for the memory port.
 * Assumes the bus wires are resolved in sep_if on the same clock.
 */
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "sep_map.svh"

module sep_host #(
	parameter int QDIV = (`SEP_SCL_NS + 4 * `SEP_CLK_NS - 1) / (4 * `SEP_CLK_NS)
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Two-wire bus
	sep_if.host bus
);

	// Device answers trail SCL by its input filter, so a quarter needs margin.
	if (QDIV < 8 || QDIV > 65535) begin : g_bad_qdiv
		$error("QDIV must be 8 to 65535");
	end

	sep_pkg::sep_host_t r;
	sep_pkg::sep_host_t n;
	logic q;
	logic last;
	logic hit;
	logic sa;
	logic sb;
	logic [3:0] elen;
	logic [31:0] rv;

	assign q = (r.st != sep_pkg::H_IDLE) && (r.div == 16'(QDIV - 1));
	assign elen = (r.len == 4'h0) ? 4'h1 : r.len;
	assign last = (r.idx + 4'h1) == elen;
	assign pready = psel && penable;
	assign pslverr = pready && !hit;
	assign prdata = r.prdata;

	// ----------------------------------------
	// Register decode and line levels
	// ----------------------------------------
	always_comb begin
		hit = 1'b1;
		rv = 32'h0000_0000;
		unique case (paddr)
			`SEP_R_CTRL: rv = {29'h0, r.cmd};
			`SEP_R_DEV: rv = {24'h0, r.dev};
			`SEP_R_MEM: rv = {24'h0, r.mem};
			`SEP_R_WDATA: rv = {24'h0, r.wdata};
			`SEP_R_LEN: rv = {28'h0, r.len};
			`SEP_R_STAT: rv = {30'h0, r.nack, r.busy};
			`SEP_R_RDATA: rv = {24'h0, r.rdata};
			default: hit = 1'b0;
		endcase
		sa = 1'b1;
		sb = 1'b1;
		unique case (r.st)
			sep_pkg::H_START: sb = 1'b0;
			sep_pkg::H_STOP: sa = 1'b0;
			sep_pkg::H_TX: begin
				sa = r.bit_n[3] || r.sh[7];
				sb = sa;
			end
			sep_pkg::H_RX: begin
				sa = !(r.bit_n[3] && !last);
				sb = sa;
			end
			sep_pkg::H_IDLE, sep_pkg::H_RCV: begin
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		n = r;
		if (psel && !penable) begin
			n.prdata = rv;
		end
		if (pready && pwrite) begin
			unique case (paddr)
				`SEP_R_DEV: n.dev = pwdata[7:0];
				`SEP_R_MEM: n.mem = pwdata[7:0];
				`SEP_R_WDATA: n.wdata = pwdata[7:0];
				`SEP_R_LEN: n.len = pwdata[3:0];
				`SEP_R_CTRL: begin
					if (pwdata[`SEP_CTRL_GO] && !r.busy && pwdata[2:0] <= `SEP_CMD_MAX) begin
						n.cmd = sep_pkg::sep_cmd_t'(pwdata[2:0]);
						n.busy = 1'b1;
						n.nack = 1'b0;
						n.idx = 4'h0;
						n.rcv = 4'h0;
						n.ph = 2'h0;
						n.div = 16'h0000;
						n.step = (pwdata[2:0] == sep_pkg::C_CUR) ? sep_pkg::S_DEVR
							: (pwdata[2:0] == sep_pkg::C_RECOVER) ? sep_pkg::S_NONE
							: sep_pkg::S_DEVW;
						n.st = (pwdata[2:0] == sep_pkg::C_RECOVER) ? sep_pkg::H_RCV
							: sep_pkg::H_START;
					end
				end
				default: begin
				end
			endcase
		end
		if (r.st != sep_pkg::H_IDLE) begin
			n.div = q ? 16'h0000 : r.div + 16'h0001;
		end
		if (q) begin
			n.ph = r.ph + 2'h1;
			unique case (r.ph)
				2'h0: begin
					n.scl_lvl = 1'b0;
					n.sda_lvl = sa;
				end
				2'h1: n.scl_lvl = 1'b1;
				2'h2: begin
					n.samp = bus.sda;
					n.sda_lvl = sb;
				end
				2'h3: begin
					n.scl_lvl = (r.st == sep_pkg::H_STOP);
					n.bit_n = 4'h0;
					unique case (r.st)
						sep_pkg::H_START: begin
							if (r.step == sep_pkg::S_NONE) begin
								n.st = sep_pkg::H_STOP;
							end else begin
								n.st = sep_pkg::H_TX;
								n.sh = {r.dev[7:1], r.step == sep_pkg::S_DEVR};
							end
						end
						sep_pkg::H_STOP: begin
							n.st = sep_pkg::H_IDLE;
							n.busy = 1'b0;
						end
						sep_pkg::H_RCV: begin
							n.rcv = r.rcv + 4'h1;
							if (r.samp || r.rcv == `SEP_RCV_MAX) begin
								n.st = sep_pkg::H_START;
								n.nack = !r.samp;
							end
						end
						sep_pkg::H_TX: begin
							if (!r.bit_n[3]) begin
								n.bit_n = r.bit_n + 4'h1;
								n.sh = {r.sh[6:0], 1'b0};
							end else if (r.samp) begin
								n.nack = 1'b1;
								n.st = sep_pkg::H_STOP;
							end else begin
								unique case (r.step)
									sep_pkg::S_DEVW: begin
										if (r.cmd == sep_pkg::C_POLL) begin
											n.st = sep_pkg::H_STOP;
										end else begin
											n.step = sep_pkg::S_MEM;
											n.sh = r.mem;
										end
									end
									sep_pkg::S_MEM: begin
										if (r.cmd == sep_pkg::C_WRITE) begin
											n.step = sep_pkg::S_DATA;
											n.sh = r.wdata;
										end else begin
											n.step = sep_pkg::S_DEVR;
											n.st = sep_pkg::H_START;
										end
									end
									sep_pkg::S_DATA: begin
										n.idx = r.idx + 4'h1;
										n.sh = r.wdata + 8'(r.idx) + 8'h01;
										if (last) begin
											n.st = sep_pkg::H_STOP;
										end
									end
									sep_pkg::S_DEVR: begin
										n.st = sep_pkg::H_RX;
										n.step = sep_pkg::S_RD;
									end
									sep_pkg::S_NONE, sep_pkg::S_RD: begin
									end
								endcase
							end
						end
						sep_pkg::H_RX: begin
							if (!r.bit_n[3]) begin
								n.bit_n = r.bit_n + 4'h1;
								n.sh = {r.sh[6:0], r.samp};
							end else begin
								n.rdata = r.sh;
								n.idx = r.idx + 4'h1;
								if (last) begin
									n.st = sep_pkg::H_STOP;
								end
							end
						end
						sep_pkg::H_IDLE: begin
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.scl_lvl <= 1'b1;
			r.sda_lvl <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign bus.scl_h_o = 1'b0;
	assign bus.scl_h_oe = !r.scl_lvl;
	assign bus.sda_h_o = 1'b0;
	assign bus.sda_h_oe = !r.sda_lvl;

endmodule : sep_host

//--- rtl/sep_map.svh
/*
 * Addresses, field positions and timing figures of the two-wire memory port.
 * Assumes inclusion by bare name from rtl/ sources.
 */
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH

// ----------------------------------------
// Device memory map
// ----------------------------------------
`define SEP_A_STATUS 8'h6E
`define SEP_A_TSEL 8'h7F
`define SEP_A_CHIP 8'hD0
`define SEP_T_CHIP 8'h03
`define SEP_TABLES 8'h04
`define SEP_FIXED_ADDR 8'hA0
`define SEP_CHIP_RST 8'hA2
`define SEP_MIR_PAD 4'h0

// ----------------------------------------
// Synchroniser lanes
// ----------------------------------------
`define SEP_I_SCL 0
`define SEP_I_SDA 1
`define SEP_I_ADDRESS_SELECT_PIN 2
`define SEP_I_N 7
`define SEP_PIN_IDLE 7'h03

// ----------------------------------------
// Timing
// ----------------------------------------
`define SEP_CLK_NS 4
`define SEP_TW_NS 10000
`define SEP_SCL_NS 2500
`define SEP_RCV_MAX 4'h8

// ----------------------------------------
// Host controller registers
// ----------------------------------------
`define SEP_R_CTRL 8'h00
`define SEP_R_DEV 8'h04
`define SEP_R_MEM 8'h08
`define SEP_R_WDATA 8'h0C
`define SEP_R_LEN 8'h10
`define SEP_R_STAT 8'h14
`define SEP_R_RDATA 8'h18
`define SEP_CTRL_GO 3
`define SEP_CMD_MAX 3'h4

`endif

//--- rtl/sep_pkg.sv
/*
 * Types shared by both ends of the two-wire memory port.
 * Assumes sep_map.svh is on the include path.
 */
`include "sep_map.svh"

package sep_pkg;

	// ----------------------------------------
	// Device end
	// ----------------------------------------
	typedef enum logic [2:0] {D_IDLE, D_RX, D_ACKW, D_ACKH, D_TX, D_TXA, D_TXN} sep_dst_t;
	typedef enum logic [1:0] {K_ADDR, K_MEM, K_DATA} sep_kind_t;

	typedef struct packed {
		logic [`SEP_I_N-1:0] sy1;
		logic [`SEP_I_N-1:0] sy2;
		logic [`SEP_I_N-1:0] sy3;
		logic [`SEP_I_N-1:0] filt;
		logic scl_p;
		logic sda_p;
		sep_dst_t st;
		sep_kind_t kind;
		logic rw;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic [7:0][7:0] pbuf;
		logic [7:0] pvld;
		logic [15:0] busy;
		logic sda_low;
		logic [127:0][7:0] low;
		logic [2:0][127:0][7:0] up;
	} sep_dev_t;

	// ----------------------------------------
	// Host end
	// ----------------------------------------
	typedef enum logic [2:0] {H_IDLE, H_RCV, H_START, H_TX, H_RX, H_STOP} sep_hst_t;
	typedef enum logic [2:0] {S_NONE, S_DEVW, S_MEM, S_DATA, S_DEVR, S_RD} sep_step_t;
	typedef enum logic [2:0] {C_WRITE, C_RAND, C_CUR, C_POLL, C_RECOVER} sep_cmd_t;

	typedef struct packed {
		sep_hst_t st;
		sep_step_t step;
		sep_cmd_t cmd;
		logic [1:0] ph;
		logic [3:0] bit_n;
		logic [3:0] idx;
		logic [3:0] rcv;
		logic [7:0] sh;
		logic samp;
		logic scl_lvl;
		logic sda_lvl;
		logic [15:0] div;
		logic [7:0] dev;
		logic [7:0] mem;
		logic [7:0] wdata;
		logic [3:0] len;
		logic busy;
		logic nack;
		logic [7:0] rdata;
		logic [31:0] prdata;
	} sep_host_t;

endpackage : sep_pkg

//--- rtl/sep_if.sv
/*
 * Two-wire bus between host and device ends, resolved as open-drain wires.
 * Assumes each end drives only its enables; the pulled-up level is one.
 */
`timescale 1ns/1ps

interface sep_if;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	assign scl = !(scl_h_oe && !scl_h_o);
	assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

	modport dev(input scl, input sda, output sda_d_o, output sda_d_oe);
	modport host(input scl, input sda, output scl_h_o, output scl_h_oe, output sda_h_o,
		output sda_h_oe);
endinterface : sep_if

//--- rtl/sep_device.sv
/*
 * Device end: two-wire slave with table memory, page write and status mirror.
 * Assumes the bus and strap pins are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`include "sep_map.svh"

// What this block does
// - Falling SDA with SCL high is start.
// - SDA change during SCL high is control only.
// - Rising SDA with SCL high stops, idles.
// - Pull SDA low on ninth clock to acknowledge.
// - Idle after reset, stop, write completion.
// - Host recovers bus with nine clocks, start.
// - Address byte first, MSB first, direction last.
// - Strap picks fixed or stored slave address.
// - Direction one reads, zero writes.
// - Write carries memory address, then data, acknowledged.
// - Stop commits write; start discards it.
// - Timed write blocks all acknowledges.
// - Page write takes up to eight bytes.
// - Write address wraps inside eight-byte page.
// - Address acknowledged again once write ends.
// - Address register holds last access plus one.
// - Current read returns byte at address register.
// - Random read uses dummy write, repeated start.
// - Master acknowledge continues read; wraps at top.
// - Four input levels mirrored into status byte.
// - Upper half steered by table select byte.
module sep_device #(
	parameter int TW_CYCLES = (`SEP_TW_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Two-wire bus
	sep_if.dev bus,
	// Strap and mirrored inputs
	input wire logic address_select_pin,
	input wire logic tx_disable_in,
	input wire logic rate_select_input,
	input wire logic tx_fault_in,
	input wire logic loss_of_signal_in,
	// Status
	output logic standby
);

	if (TW_CYCLES < 1 || TW_CYCLES > 65535) begin : g_bad_tw
		$error("TW_CYCLES must fit the 16-bit write timer");
	end

	// ----------------------------------------
	// Memory access helpers
	// ----------------------------------------
	function automatic logic [7:0] mem_rd(input sep_pkg::sep_dev_t s, input logic [7:0] a,
		input logic [7:0] mir);
		logic [7:0] t;
		t = s.low[7'(`SEP_A_TSEL)];
		if (a == `SEP_A_STATUS) begin
			mem_rd = mir;
		end else if (!a[7]) begin
			mem_rd = s.low[a[6:0]];
		end else if (t != 8'h00 && t < `SEP_TABLES) begin
			mem_rd = s.up[2'(t - 8'h01)][a[6:0]];
		end else begin
			mem_rd = 8'h00;
		end
	endfunction : mem_rd

	// ----------------------------------------
	// State and decoded events
	// ----------------------------------------
	sep_pkg::sep_dev_t r;
	sep_pkg::sep_dev_t n;
	logic [`SEP_I_N-1:0] pins;
	logic sda_in;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic load_b;
	logic [7:0] byte_in;
	logic [7:0] mirror;
	logic [7:0] slave;
	logic [7:0] tsel;
	logic [7:0] rd_b;
	logic [7:0] wa;

	assign pins = {tx_disable_in, rate_select_input, tx_fault_in, loss_of_signal_in,
		address_select_pin, bus.sda, bus.scl};
	assign sda_in = r.filt[`SEP_I_SDA];
	assign scl_rise = r.filt[`SEP_I_SCL] && !r.scl_p;
	assign scl_fall = !r.filt[`SEP_I_SCL] && r.scl_p;
	// Edges of SDA under a steady high SCL are conditions, never data.
	assign start_c = r.filt[`SEP_I_SCL] && r.scl_p && !sda_in && r.sda_p;
	assign stop_c = r.filt[`SEP_I_SCL] && r.scl_p && sda_in && !r.sda_p;
	assign byte_in = {r.sh[6:0], sda_in};
	assign mirror = {r.filt[`SEP_I_N-1:`SEP_I_ADDRESS_SELECT_PIN+1], `SEP_MIR_PAD};
	assign tsel = r.low[7'(`SEP_A_TSEL)];
	assign slave = r.filt[`SEP_I_ADDRESS_SELECT_PIN] ? r.up[2'(`SEP_T_CHIP - 8'h01)][7'(`SEP_A_CHIP)]
		: `SEP_FIXED_ADDR;
	assign load_b = scl_fall && ((r.st == sep_pkg::D_ACKH && r.rw) || r.st == sep_pkg::D_TXN);
	assign rd_b = mem_rd(r, r.ptr, mirror);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		n = r;
		wa = 8'h00;
		n.sy1 = pins;
		n.sy2 = r.sy1;
		n.sy3 = r.sy2;
		// A lane only moves once two stages agree, which rejects one-sample glitches.
		for (int i = 0; i < `SEP_I_N; i++) begin
			if (r.sy2[i] == r.sy3[i]) begin
				n.filt[i] = r.sy3[i];
			end
		end
		n.scl_p = r.filt[`SEP_I_SCL];
		n.sda_p = sda_in;
		if (r.busy != 16'h0000) begin
			n.busy = r.busy - 16'h0001;
		end
		if (start_c) begin
			// A start in place of the stop drops every byte of the open write.
			n.st = sep_pkg::D_RX;
			n.kind = sep_pkg::K_ADDR;
			n.cnt = 3'h0;
			n.sda_low = 1'b0;
			n.pvld = 8'h00;
		end else if (stop_c) begin
			n.st = sep_pkg::D_IDLE;
			n.sda_low = 1'b0;
			if (r.pvld != 8'h00) begin
				n.busy = 16'(TW_CYCLES);
				n.pvld = 8'h00;
				for (int i = 0; i < 8; i++) begin
					if (r.pvld[i]) begin
						wa = {r.ptr[7:3], 3'(i)};
						if (!wa[7]) begin
							if (wa != `SEP_A_STATUS) begin
								n.low[wa[6:0]] = r.pbuf[i];
							end
						end else if (tsel != 8'h00 && tsel < `SEP_TABLES) begin
							n.up[2'(tsel - 8'h01)][wa[6:0]] = r.pbuf[i];
						end
					end
				end
			end
		end else begin
			unique case (r.st)
				sep_pkg::D_IDLE: begin
				end
				sep_pkg::D_RX: begin
					if (scl_rise) begin
						n.sh = byte_in;
						n.cnt = r.cnt + 3'h1;
						if (r.cnt == 3'h7) begin
							n.st = sep_pkg::D_ACKW;
							unique case (r.kind)
								sep_pkg::K_ADDR: begin
									// Polling gets no acknowledge while the write timer runs.
									if (byte_in[7:1] != slave[7:1] || r.busy != 16'h0000) begin
										n.st = sep_pkg::D_IDLE;
									end else begin
										n.rw = byte_in[0];
									end
								end
								sep_pkg::K_MEM: begin
									n.ptr = byte_in;
									n.pvld = 8'h00;
								end
								sep_pkg::K_DATA: begin
									n.pbuf[r.ptr[2:0]] = byte_in;
									n.pvld[r.ptr[2:0]] = 1'b1;
									n.ptr[2:0] = r.ptr[2:0] + 3'h1;
								end
							endcase
						end
					end
				end
				sep_pkg::D_ACKW: begin
					if (scl_fall) begin
						n.sda_low = 1'b1;
						n.st = sep_pkg::D_ACKH;
					end
				end
				sep_pkg::D_ACKH: begin
					if (scl_fall) begin
						n.sda_low = 1'b0;
						if (!r.rw) begin
							n.st = sep_pkg::D_RX;
							n.kind = (r.kind == sep_pkg::K_ADDR) ? sep_pkg::K_MEM
								: sep_pkg::K_DATA;
						end
					end
				end
				sep_pkg::D_TX: begin
					if (scl_fall) begin
						n.cnt = r.cnt + 3'h1;
						n.sh = {r.sh[6:0], 1'b0};
						n.sda_low = !r.sh[6];
						if (r.cnt == 3'h7) begin
							n.sda_low = 1'b0;
							n.st = sep_pkg::D_TXA;
						end
					end
				end
				sep_pkg::D_TXA: begin
					// A missing acknowledge leaves SDA free for the master's stop.
					if (scl_rise) begin
						n.st = sda_in ? sep_pkg::D_IDLE : sep_pkg::D_TXN;
					end
				end
				sep_pkg::D_TXN: begin
				end
			endcase
			if (load_b) begin
				n.st = sep_pkg::D_TX;
				n.cnt = 3'h0;
				n.sh = rd_b;
				n.sda_low = !rd_b[7];
				n.ptr = r.ptr + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.sy1 <= `SEP_PIN_IDLE;
			r.sy2 <= `SEP_PIN_IDLE;
			r.sy3 <= `SEP_PIN_IDLE;
			r.filt <= `SEP_PIN_IDLE;
			r.scl_p <= 1'b1;
			r.sda_p <= 1'b1;
			r.up[2'(`SEP_T_CHIP - 8'h01)][7'(`SEP_A_CHIP)] <= `SEP_CHIP_RST;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus.sda_d_o = 1'b0;
	assign bus.sda_d_oe = r.sda_low;
	assign standby = (r.st == sep_pkg::D_IDLE) && (r.busy == 16'h0000);

endmodule : sep_device

//--- verification/sep_link_props.sv
/*
 * Checker for the two-wire link between host and device ends.
 * Assumes it is instantiated beside sep_if and sees the wires on core_clk.
 */
`timescale 1ns/1ps

module sep_link_props #(
	parameter int TW_CYCLES = 600
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Drivers of the wires
	input wire logic scl_h_o,
	input wire logic scl_h_oe,
	input wire logic sda_h_o,
	input wire logic sda_h_oe,
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	// Resolved wires and device status
	input wire logic scl,
	input wire logic sda,
	input wire logic standby
);
	localparam int SB_MAX = TW_CYCLES + 40;
	logic scl_q;
	logic sda_q;
	logic start_ev;
	logic stop_ev;
	logic [3:0] bitc;

	assign start_ev = scl && scl_q && sda_q && !sda;
	assign stop_ev = scl && scl_q && !sda_q && sda;

	// Counts SCL rises after a start, so the address byte can be told apart.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bitc <= 4'hF;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start_ev) begin
				bitc <= 4'h0;
			end else if (scl && !scl_q && bitc != 4'hF) begin
				bitc <= bitc + 4'h1;
			end
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_dev_od_low: assert property (sda_d_oe |-> !sda_d_o)
		else $error("device drives SDA high");
	a_host_sda_cond: assert property ($changed(sda_h_oe) && scl |-> (start_ev || stop_ev))
		else $error("host moved SDA under high SCL outside a condition");
	a_dev_scl_low: assert property ($changed(sda_d_oe) |-> !scl)
		else $error("device changed SDA while SCL high");
	a_idle_release: assert property (standby |-> !sda_d_oe)
		else $error("idle device holds SDA");
	a_addr_no_drive: assert property (bitc < 4'h8 |-> !sda_d_oe)
		else $error("device drove SDA inside the address byte");
	a_start_wakes: assert property (start_ev |-> ##[1:10] !standby)
		else $error("start not taken by device");
	a_stop_idles: assert property (stop_ev |-> ##[1:SB_MAX] (standby || start_ev))
		else $error("device not idle after stop");
	a_bus_free: assert property (stop_ev |=> (scl && sda) [*2])
		else $error("bus not free after stop");
endmodule : sep_link_props

//--- verification/serial_eeprom_slave_port_tb_top.sv
/*
 * Bench: APB host end drives the device end over sep_if; checker on the wires.
 * Assumes rtl/ on the include path and sep_pkg compiled first.
 */
`timescale 1ns/1ps
`include "sep_map.svh"

module serial_eeprom_slave_port_tb_top;
	// Long enough that an early poll lands inside the timed write.
	localparam int TW = 600;
	logic core_clk;
	logic rst_n;
	logic [7:0] paddr;
	logic psel, penable, pwrite, pready, pslverr, perr, nack;
	logic [31:0] pwdata, prdata, q;
	logic address_select_pin, tx_disable_in, rate_select_input, tx_fault_in, loss_of_signal_in;
	logic standby;
	int miscompares, n_compared;

	sep_if sep_if_i();
	sep_host #(.QDIV(8)) sep_host_i(.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(sep_if_i.host));
	sep_device #(.TW_CYCLES(TW)) sep_device_i(.core_clk(core_clk), .rst_n(rst_n),
		.bus(sep_if_i.dev), .address_select_pin(address_select_pin),
		.tx_disable_in(tx_disable_in), .rate_select_input(rate_select_input),
		.tx_fault_in(tx_fault_in), .loss_of_signal_in(loss_of_signal_in), .standby(standby));
	sep_link_props #(.TW_CYCLES(TW)) sep_link_props_i(.core_clk(core_clk), .rst_n(rst_n),
		.scl_h_o(sep_if_i.scl_h_o), .scl_h_oe(sep_if_i.scl_h_oe), .sda_h_o(sep_if_i.sda_h_o),
		.sda_h_oe(sep_if_i.sda_h_oe), .sda_d_o(sep_if_i.sda_d_o), .sda_d_oe(sep_if_i.sda_d_oe),
		.scl(sep_if_i.scl), .sda(sep_if_i.sda), .standby(standby));

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic go(input sep_pkg::sep_cmd_t c, input logic [7:0] dev, input logic [7:0] mem,
		input logic [7:0] wd, input logic [3:0] len);
		int n;
		apb(1'b1, `SEP_R_DEV, {24'h000000, dev});
		apb(1'b1, `SEP_R_MEM, {24'h000000, mem});
		apb(1'b1, `SEP_R_WDATA, {24'h000000, wd});
		apb(1'b1, `SEP_R_LEN, {28'h0000000, len});
		apb(1'b1, `SEP_R_CTRL, {28'h0000000, 1'b1, c});
		n = 0;
		q = 32'h00000001;
		while (q[0] !== 1'b0 && n < 4000) begin
			apb(1'b0, `SEP_R_STAT, 32'h00000000);
			n++;
		end
		nack = q[1];
		chk({31'h0, q[0]}, 32'h0, "host never went idle");
	endtask : go

	task automatic settle(input logic [7:0] dev);
		int n;
		n = 0;
		nack = 1'b1;
		while (nack !== 1'b0 && n < 20) begin
			go(sep_pkg::C_POLL, dev, 8'h00, 8'h00, 4'h0);
			n++;
		end
		chk({31'h0, nack}, 32'h0, "poll never acknowledged");
	endtask : settle

	task automatic wr(input logic [7:0] dev, input logic [7:0] mem, input logic [7:0] wd,
		input logic [3:0] len);
		go(sep_pkg::C_WRITE, dev, mem, wd, len);
		chk({31'h0, nack}, 32'h0, "write refused");
		settle(dev);
	endtask : wr

	task automatic rd(input logic [7:0] dev, input logic [7:0] mem, input logic [7:0] exp);
		go(sep_pkg::C_RAND, dev, mem, 8'h00, 4'h1);
		chk({31'h0, nack}, 32'h0, "read refused");
		apb(1'b0, `SEP_R_RDATA, 32'h0);
		chk(q, {24'h000000, exp}, "read byte");
	endtask : rd

	task automatic report_and_stop();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (90000) @(posedge core_clk);
		miscompares++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{address_select_pin, tx_disable_in, rate_select_input} = 3'h2;
		{tx_fault_in, loss_of_signal_in} = 2'h3;
		miscompares = 0;
		n_compared = 0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, perr}, 32'h1, "unmapped not flagged");
		chk(q, 32'h0, "unmapped read");
		$display("done: host registers");
		go(sep_pkg::C_WRITE, 8'hA0, 8'h06, 8'h10, 4'h4);
		chk({31'h0, nack}, 32'h0, "first page write refused");
		go(sep_pkg::C_POLL, 8'hA0, 8'h00, 8'h00, 4'h0);
		chk({31'h0, nack}, 32'h1, "ack during timed write");
		settle(8'hA0);
		rd(8'hA0, 8'h00, 8'h12);
		rd(8'hA0, 8'h01, 8'h13);
		rd(8'hA0, 8'h08, 8'h00);
		rd(8'hA0, 8'h06, 8'h10);
		go(sep_pkg::C_CUR, 8'hA1, 8'h00, 8'h00, 4'h1);
		chk({31'h0, nack}, 32'h0, "current read refused");
		apb(1'b0, `SEP_R_RDATA, 32'h0);
		chk(q, 32'h00000011, "current read");
		$display("done: page write and current read");
		wr(8'hA0, 8'h10, 8'h20, 4'hA);
		rd(8'hA0, 8'h10, 8'h28);
		rd(8'hA0, 8'h12, 8'h22);
		go(sep_pkg::C_RAND, 8'hA0, 8'hFE, 8'h00, 4'h3);
		chk({31'h0, nack}, 32'h0, "sequential read refused");
		apb(1'b0, `SEP_R_RDATA, 32'h0);
		chk(q, 32'h00000012, "sequential wrap");
		$display("done: overflow and sequential read");
		rd(8'hA0, `SEP_A_STATUS, 8'hB0);
		{tx_disable_in, rate_select_input, tx_fault_in, loss_of_signal_in} <= 4'h4;
		rd(8'hA0, `SEP_A_STATUS, 8'h40);
		$display("done: input mirror");
		wr(8'hA0, `SEP_A_TSEL, `SEP_T_CHIP, 4'h1);
		rd(8'hA0, `SEP_A_CHIP, 8'hA2);
		address_select_pin <= 1'b1;
		go(sep_pkg::C_RAND, 8'hA0, `SEP_A_CHIP, 8'h00, 4'h1);
		chk({31'h0, nack}, 32'h1, "fixed address taken with strap high");
		rd(8'hA2, `SEP_A_CHIP, 8'hA2);
		wr(8'hA2, `SEP_A_TSEL, 8'h01, 4'h1);
		rd(8'hA2, `SEP_A_CHIP, 8'h00);
		$display("done: strap and tables");
		go(sep_pkg::C_RECOVER, 8'hA2, 8'h00, 8'h00, 4'h0);
		chk({31'h0, nack}, 32'h0, "recover failed");
		apb(1'b0, `SEP_R_CTRL, 32'h0);
		chk(q, 32'h00000004, "last command");
		$display("done: recover");
		report_and_stop();
	end
endmodule : serial_eeprom_slave_port_tb_top
